// ===== crs_pkg.sv
// Purpose: Constants for the clock, reset and suspend controller
// Assumes: Core clock of 20 MHz
// Notes: Register indices are 8-bit I/O addresses
package crs_pkg;
	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_PORT2 = 8'h02;
	localparam logic [7:0] ADDR_WDOG_RESTART = 8'h26;
	localparam logic [7:0] ADDR_CLK_CFG = 8'hF8;
	localparam logic [7:0] ADDR_PROC_STAT = 8'hFF;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CFG_EXT_EN = 0;
	localparam int CFG_CLKOUT_DIS = 1;
	localparam int CFG_LVR_DIS = 3;
	localparam int CFG_RESUME_LONG = 7;
	localparam int STAT_RUN = 0;
	localparam int STAT_SUSPEND = 3;
	localparam int STAT_LVR_FLAG = 4;
	localparam int STAT_WDR_FLAG = 6;
	localparam int PORT2_AUX_BIT = 1;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] STAT_RESET_LVR = 8'h11;
	localparam logic [7:0] STAT_RESET_WDR = 8'h41;
	localparam logic [7:0] STACK_RESET = 8'h00;
	localparam logic [13:0] PC_RESET = 14'h0000;
	// ----------------------------------------
	// Times and cycle counts
	// ----------------------------------------
	localparam int CLK_MHZ = 20;
	localparam int RESUME_SHORT_US = 128;
	localparam int RESUME_LONG_MS = 4;
	localparam int WAKE_INT_US = 8;
	localparam int WDOG_PERIOD_MS = 10;
	localparam int WDR_HOLD_MS = 2;
	localparam int SETTLE_US = 1000;
	localparam int RESUME_SHORT_CYC = RESUME_SHORT_US * CLK_MHZ;
	localparam int RESUME_LONG_CYC = RESUME_LONG_MS * 1000 * CLK_MHZ;
	localparam int WAKE_INT_CYC = WAKE_INT_US * CLK_MHZ;
	localparam int WDOG_PERIOD_CYC = WDOG_PERIOD_MS * 1000 * CLK_MHZ;
	localparam int WDR_HOLD_CYC = WDR_HOLD_MS * 1000 * CLK_MHZ;
	localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
	localparam int CNT_W = 20;
	typedef enum {
		CRS_SETTLE, CRS_RUN, CRS_OSC_WAIT, CRS_RESUME, CRS_WDR_HOLD, CRS_SUSPEND
	} crs_state_t;
endpackage : crs_pkg

// ===== crs_ctrl.sv
// Purpose: Clock source selection, reset sequencing and suspend entry
// Assumes: Analog trips and oscillator stability arrive as asynchronous levels
// Notes: Oscillators themselves are outside; this logic drives their enables
`timescale 1ns/1ps
module crs_ctrl
	import crs_pkg::*;
#(
	parameter int WDOG_CYC = WDOG_PERIOD_CYC,
	parameter int WDR_CYC = WDR_HOLD_CYC,
	parameter int SETTLE = SETTLE_CYC,
	parameter int RES_LONG = RESUME_LONG_CYC
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_supply_low,
	input wire logic i_brownout_trip,
	input wire logic i_ext_osc_stable,
	input wire logic i_int_clk,
	input wire logic i_osc_input_pin,
	input wire logic i_wake_irq,
	input wire logic i_usb_minus_line,
	output logic o_int_osc_en,
	output logic o_ext_osc_en,
	output logic o_clk_from_ext,
	output logic o_chip_clk_en,
	output logic o_cpu_hold,
	output logic o_sys_reset,
	output logic [13:0] o_pc_load,
	output logic o_osc_output_pin,
	output logic o_osc_input_pulldown,
	output logic o_low_voltage_reset_en,
	output logic o_brownout_reset_en,
	output logic o_timer_run,
	output logic [7:0] o_program_stack_pointer,
	output logic [7:0] o_data_stack_pointer
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		crs_state_t st;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] wdog;
		logic [7:0] cfg;
		logic [7:0] stat;
		logic ext_mode;
		logic [7:0] rdata;
		logic [1:0] s_low;
		logic [1:0] s_bor;
		logic [1:0] s_stab;
		logic [1:0] s_xin;
		logic [1:0] s_dm;
		logic [1:0] s_wk;
	} crs_regs_t;
	crs_regs_t r;
	crs_regs_t next_r;
	logic low, bor, stab, dm_low, wake, lvr_on, bor_on, v_rst, wd_hit;
	logic wr_restart, wr_cfg, wr_stat;
	logic [CNT_W-1:0] resume_end;
	function automatic logic [CNT_W-1:0] resume_cycles(input logic long_sel);
		resume_cycles = long_sel ? CNT_W'(RES_LONG) : CNT_W'(RESUME_SHORT_CYC);
	endfunction : resume_cycles
	function automatic logic bus_write(input logic wr, input logic [7:0] addr,
		input logic [7:0] target);
		bus_write = wr && (addr == target);
	endfunction : bus_write
	always_comb begin
		low = r.s_low[1];
		bor = r.s_bor[1];
		stab = r.s_stab[1];
		dm_low = !r.s_dm[1];
		wake = r.s_wk[1] || dm_low;
		lvr_on = !r.cfg[CFG_LVR_DIS] && (r.st != CRS_SUSPEND);
		bor_on = !lvr_on;
		v_rst = (lvr_on && low) || (bor_on && bor);
		wd_hit = (r.wdog >= CNT_W'(WDOG_CYC - 1)) && (r.st == CRS_RUN);
		wr_restart = bus_write(i_wr, i_addr, ADDR_WDOG_RESTART);
		wr_cfg = bus_write(i_wr, i_addr, ADDR_CLK_CFG);
		wr_stat = bus_write(i_wr, i_addr, ADDR_PROC_STAT);
		// Internal wake never uses the long external delay
		resume_end = r.ext_mode ? resume_cycles(r.cfg[CFG_RESUME_LONG]) : CNT_W'(RESUME_SHORT_CYC);
		next_r = r;
		// Two-flop synchronisers
		next_r.s_low = {r.s_low[0], i_supply_low};
		next_r.s_bor = {r.s_bor[0], i_brownout_trip};
		next_r.s_stab = {r.s_stab[0], i_ext_osc_stable};
		next_r.s_xin = {r.s_xin[0], i_osc_input_pin};
		next_r.s_dm = {r.s_dm[0], i_usb_minus_line};
		next_r.s_wk = {r.s_wk[0], i_wake_irq};
		next_r.cnt = r.cnt + CNT_W'(1);
		// Watchdog runs only while executing; any write to restart clears
		if (r.st == CRS_RUN && !wr_restart) begin
			next_r.wdog = r.wdog + CNT_W'(1);
		end else begin
			next_r.wdog = '0;
		end
		// ----------------------------------------
		// Register reads: data valid next cycle
		// ----------------------------------------
		next_r.rdata = 8'h00;
		if (i_rd) begin
			case (i_addr)
				ADDR_CLK_CFG: next_r.rdata = r.cfg;
				ADDR_PROC_STAT: next_r.rdata = r.stat;
				ADDR_PORT2: next_r.rdata = {6'h00, !r.ext_mode && r.s_xin[1], 1'b0};
				default: next_r.rdata = 8'h00;
			endcase
		end
		if (wr_cfg) begin
			next_r.cfg = i_wdata & 8'hFB;
			next_r.cfg[2] = i_wdata[2];
		end
		if (wr_stat) begin
			next_r.stat = i_wdata;
		end
		// ----------------------------------------
		// Sequencer
		// ----------------------------------------
		case (r.st)
			CRS_RUN: begin
				if (wr_cfg && i_wdata[CFG_EXT_EN] && !r.ext_mode) begin
					next_r.st = CRS_OSC_WAIT;
					next_r.ext_mode = 1'b1;
				end else if (wr_stat && i_wdata[STAT_SUSPEND]) begin
					next_r.st = CRS_SUSPEND;
				end
			end
			CRS_OSC_WAIT: begin
				next_r.cnt = '0;
				if (stab) begin
					next_r.st = CRS_RESUME;
				end
			end
			CRS_RESUME: begin
				if (r.cnt >= resume_end - CNT_W'(1)) begin
					next_r.st = CRS_RUN;
				end
			end
			CRS_SUSPEND: begin
				next_r.cnt = '0;
				next_r.stat[STAT_SUSPEND] = 1'b0;
				if (wake) begin
					next_r.ext_mode = r.cfg[CFG_EXT_EN];
					if (r.cfg[CFG_EXT_EN]) begin
						next_r.st = CRS_OSC_WAIT;
					end else begin
						next_r.st = CRS_RESUME;
						next_r.cnt = CNT_W'(RESUME_SHORT_CYC - WAKE_INT_CYC);
					end
				end
			end
			CRS_WDR_HOLD: begin
				if (r.cnt >= CNT_W'(WDR_CYC - 1)) begin
					next_r.st = CRS_RUN;
				end
			end
			CRS_SETTLE: begin
				if (low) begin
					next_r.cnt = '0;
				end else if (r.cnt >= CNT_W'(SETTLE - 1)) begin
					next_r.st = CRS_RUN;
				end
			end
			default: next_r.st = CRS_SETTLE;
		endcase
		// Resets take priority over everything
		if (v_rst) begin
			next_r.st = CRS_SETTLE;
			next_r.cnt = '0;
			next_r.ext_mode = 1'b0;
			next_r.cfg = CFG_RESET;
			next_r.stat = STAT_RESET_LVR;
		end else if (wd_hit) begin
			next_r.st = CRS_WDR_HOLD;
			next_r.cnt = '0;
			next_r.cfg = CFG_RESET;
			next_r.stat = STAT_RESET_WDR;
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			r <= '{st: CRS_SETTLE, cnt: '0, wdog: '0, cfg: CFG_RESET, stat: STAT_RESET_LVR,
				ext_mode: 1'b0, rdata: 8'h00, s_low: 2'b11, s_bor: 2'b00, s_stab: 2'b00,
				s_xin: 2'b00, s_dm: 2'b11, s_wk: 2'b00};
		end else begin
			r <= next_r;
		end
	end
	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_comb begin
		o_rdata = r.rdata;
		o_int_osc_en = !r.ext_mode && r.st != CRS_SUSPEND;
		o_ext_osc_en = r.ext_mode && r.st != CRS_SUSPEND;
		o_clk_from_ext = r.ext_mode;
		o_chip_clk_en = !(r.st == CRS_OSC_WAIT || r.st == CRS_SUSPEND);
		o_cpu_hold = r.st != CRS_RUN;
		o_sys_reset = r.st == CRS_SETTLE || r.st == CRS_WDR_HOLD;
		o_pc_load = PC_RESET;
		o_osc_output_pin = r.ext_mode ? 1'b0 :
			(r.cfg[CFG_CLKOUT_DIS] ? 1'b1 : i_int_clk);
		o_osc_input_pulldown = !r.ext_mode;
		o_low_voltage_reset_en = lvr_on;
		o_brownout_reset_en = bor_on;
		o_timer_run = r.st != CRS_SUSPEND;
		o_program_stack_pointer = STACK_RESET;
		o_data_stack_pointer = STACK_RESET;
	end
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_wdr_status: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(wd_hit && !v_rst) |=> (r.stat == STAT_RESET_WDR && r.st == CRS_WDR_HOLD))
		else $error("watchdog reset status wrong");
	chk_wdog_clear: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_wr && i_addr == ADDR_WDOG_RESTART) |=> r.wdog == '0)
		else $error("watchdog not cleared");
	chk_vrst_internal: assert property (@(posedge i_core_clk) disable iff (i_rst)
		v_rst |=> (!r.ext_mode && r.st == CRS_SETTLE && r.stat[STAT_LVR_FLAG]))
		else $error("voltage reset did not force internal");
	chk_ext_halt: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(r.st == CRS_OSC_WAIT) |-> (!o_chip_clk_en && o_ext_osc_en && !o_int_osc_en))
		else $error("clocks not halted while waiting");
	chk_clkout_high: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!r.ext_mode && r.cfg[CFG_CLKOUT_DIS]) |-> o_osc_output_pin)
		else $error("clock output pin not high");
	chk_suspend_off: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(r.st == CRS_SUSPEND) |-> (!o_int_osc_en && !o_ext_osc_en && !o_timer_run))
		else $error("oscillators running in suspend");
	chk_lvr_bor: assert property (@(posedge i_core_clk) disable iff (i_rst)
		o_low_voltage_reset_en != o_brownout_reset_en)
		else $error("no low voltage monitor active");
	chk_wdr_keep_clk: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(wd_hit && !v_rst) |=> $stable(r.ext_mode))
		else $error("watchdog changed clock mode");
	// ----------------------------------------
	// Output, register read, monitor and sequencing checks
	// ----------------------------------------
	chk_pc_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
		o_pc_load == PC_RESET)
		else $error("restart address not zero");
	chk_stack_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(o_program_stack_pointer == STACK_RESET) && (o_data_stack_pointer == STACK_RESET))
		else $error("stack pointers not zero");
	chk_rdata_idle: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!i_rd |=> o_rdata == 8'h00)
		else $error("read data without read");
	chk_cfg_read: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_rd && i_addr == ADDR_CLK_CFG) |=> o_rdata == $past(r.cfg))
		else $error("config read wrong");
	chk_port2_pin: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_rd && i_addr == ADDR_PORT2) |=> o_rdata == {6'h00, $past(!r.ext_mode && r.s_xin[1]), 1'b0})
		else $error("aux port read wrong");
	chk_int_pulldown: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!r.ext_mode |-> o_osc_input_pulldown)
		else $error("input pin pulldown missing");
	chk_lvr_suspend: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(r.st == CRS_SUSPEND) |-> !o_low_voltage_reset_en)
		else $error("low voltage reset on in suspend");
	chk_lvr_dis_bit: assert property (@(posedge i_core_clk) disable iff (i_rst)
		r.cfg[CFG_LVR_DIS] |-> !o_low_voltage_reset_en)
		else $error("low voltage reset not disabled");
	chk_lvr_active: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!r.cfg[CFG_LVR_DIS] && r.st != CRS_SUSPEND) |-> o_low_voltage_reset_en)
		else $error("low voltage reset not active");
	chk_bor_trip: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(bor_on && bor) |=> (r.st == CRS_SETTLE && r.cfg == CFG_RESET))
		else $error("brownout trip did not reset");
	chk_clear_no_return: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(r.ext_mode && r.st != CRS_SUSPEND && !v_rst) |=> r.ext_mode)
		else $error("left external mode outside suspend");
	chk_wake_only: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(r.st == CRS_SUSPEND && !wake && !v_rst) |=> r.st == CRS_SUSPEND)
		else $error("woke without wake source");
	chk_wake_clock: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(r.st == CRS_SUSPEND && wake && !v_rst) |=> r.ext_mode == $past(r.cfg[CFG_EXT_EN]))
		else $error("wake clock mode wrong");
	chk_wake_delay: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(r.st == CRS_SUSPEND && wake && !v_rst && !r.cfg[CFG_EXT_EN]) |=>
		(r.st == CRS_RESUME && r.cnt == CNT_W'(RESUME_SHORT_CYC - WAKE_INT_CYC)))
		else $error("internal wake delay wrong");
	chk_resume_held: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(r.st == CRS_RESUME) |-> (o_cpu_hold && o_chip_clk_en))
		else $error("resume delay not holding cpu");
	chk_osc_stable: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(r.st == CRS_OSC_WAIT && stab && !v_rst) |=> r.st == CRS_RESUME)
		else $error("stable clock did not resume");
	chk_run_free: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(r.st == CRS_RUN) |-> (o_chip_clk_en && !o_cpu_hold))
		else $error("cpu held while running");
	chk_wdr_hold_len: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(r.st == CRS_WDR_HOLD && r.cnt < CNT_W'(WDR_CYC - 1) && !v_rst) |=> r.st == CRS_WDR_HOLD)
		else $error("watchdog reset ended early");
	chk_sys_reset: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(r.st == CRS_SETTLE || r.st == CRS_WDR_HOLD) |-> (o_sys_reset && o_cpu_hold))
		else $error("system reset not asserted");
	chk_settle_wait: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(r.st == CRS_SETTLE && low) |=> (r.st == CRS_SETTLE && r.cnt == '0))
		else $error("settle count ran with supply low");
	chk_wdog_frozen: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(r.st != CRS_RUN) |=> r.wdog == '0)
		else $error("watchdog counted while not running");
	chk_timer_run: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(r.st != CRS_SUSPEND) |-> o_timer_run)
		else $error("timer stopped outside suspend");
	chk_clkout_int: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!r.ext_mode && !r.cfg[CFG_CLKOUT_DIS]) |-> o_osc_output_pin == i_int_clk)
		else $error("internal clock not on output pin");
	chk_power_int: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(r.st == CRS_SETTLE) |-> (o_int_osc_en && !o_ext_osc_en))
		else $error("settle not on internal oscillator");
	chk_wdr_cfg_clear: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(wd_hit && !v_rst) |=> !r.cfg[CFG_EXT_EN])
		else $error("watchdog kept enable bit");
endmodule : crs_ctrl

// ===== crs_osc_model.sv
// Purpose: External resonator model beside the clock controller
// Assumes: Oscillator settles a fixed count after its enable rises
// Notes: Stable drops at once when the enable falls
`timescale 1ns/1ps
module crs_osc_model #(
	parameter int START_CYC = 30
) (
	input wire logic i_core_clk,
	input wire logic i_enable,
	output logic o_stable
);
	int count = 0;
	// Start-up count restarts whenever the oscillator is switched off
	always_ff @(posedge i_core_clk) begin
		if (!i_enable) count <= 0;
		else if (count < START_CYC) count <= count + 1;
	end
	assign o_stable = i_enable && (count >= START_CYC);
endmodule : crs_osc_model

// ===== clock_reset_suspend_control_tb_top.sv
// Purpose: Self-checking bench for the clock, reset and suspend controller
// Assumes: Shortened watchdog, hold, settle and long resume counts
// Notes: Bus strobes are one cycle, driven after the rising edge
`timescale 1ns/1ps
module clock_reset_suspend_control_tb_top
	import crs_pkg::*;
;
	localparam int SET = 20;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic sup = 1'b1;
	logic bor = 1'b0;
	logic icl = 1'b0;
	logic pin = 1'b1;
	logic irq = 1'b0;
	logic usb = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wd = 8'h00;
	logic [7:0] rdat, program_stack_pointer, dsp;
	logic [13:0] pc;
	logic stab, ien, een, fext, cen, hold, srst, opin, pdn, lven, boren, trun;
	int fail_count = 0;
	int check_count = 0;
	crs_osc_model i_osc (.i_core_clk(clk), .i_enable(een), .o_stable(stab));
	crs_ctrl #(.WDOG_CYC(200), .WDR_CYC(40), .SETTLE(SET), .RES_LONG(80)) i_dut (
		.i_core_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdat), .i_supply_low(sup), .i_brownout_trip(bor), .i_ext_osc_stable(stab),
		.i_int_clk(icl), .i_osc_input_pin(pin), .i_wake_irq(irq), .i_usb_minus_line(usb),
		.o_int_osc_en(ien), .o_ext_osc_en(een), .o_clk_from_ext(fext), .o_chip_clk_en(cen),
		.o_cpu_hold(hold), .o_sys_reset(srst), .o_pc_load(pc), .o_osc_output_pin(opin),
		.o_osc_input_pulldown(pdn), .o_low_voltage_reset_en(lven),
		.o_brownout_reset_en(boren), .o_timer_run(trun), .o_program_stack_pointer(program_stack_pointer),
		.o_data_stack_pointer(dsp));
	// ----------------------------------------
	// Clock and access tasks
	// ----------------------------------------
	initial begin
		forever #25 clk = ~clk;
	end
	always @(posedge clk) icl <= ~icl;
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp8
	task automatic cmp1(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp1
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		cmp8(rdat, e);
	endtask : rd_reg
	task automatic close_out;
		if (fail_count == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : close_out
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (10000) @(posedge clk);
		fail_count++;
		close_out;
	end
	initial begin
		cyc(4);
		rst <= 1'b0;
		cyc(SET + 20);
		cmp1(srst, 1'b1);
		sup <= 1'b0;
		cyc(SET + 10);
		cmp1(srst, 1'b0);
		cmp1(hold, 1'b0);
		cmp1(pc === PC_RESET, 1'b1);
		cmp8(program_stack_pointer, STACK_RESET);
		cmp8(dsp, STACK_RESET);
		cmp1(ien, 1'b1);
		cmp1(een, 1'b0);
		cmp1(fext, 1'b0);
		cmp1(trun, 1'b1);
		cmp1(opin, icl);
		cmp1(pdn, 1'b1);
		rd_reg(ADDR_PROC_STAT, STAT_RESET_LVR);
		rd_reg(ADDR_CLK_CFG, CFG_RESET);
		rd_reg(8'h30, 8'h00);
		rd_reg(ADDR_PORT2, 8'h02);
		wr_reg(ADDR_CLK_CFG, 8'h02);
		cyc(2);
		cmp1(opin, 1'b1);
		wr_reg(ADDR_CLK_CFG, 8'h03);
		cyc(3);
		cmp1(een, 1'b1);
		cmp1(ien, 1'b0);
		cmp1(cen, 1'b0);
		cyc(40);
		cmp1(cen, 1'b1);
		cmp1(fext, 1'b1);
		cmp1(hold, 1'b1);
		cyc(RESUME_SHORT_CYC + 40);
		cmp1(hold, 1'b0);
		cmp1(opin, 1'b0);
		wr_reg(ADDR_CLK_CFG, 8'h00);
		cyc(3);
		cmp1(fext, 1'b1);
		for (int k = 0; k < 3; k++) begin
			wr_reg(ADDR_WDOG_RESTART, 8'(k));
			cyc(150);
			cmp1(srst, 1'b0);
		end
		cyc(60);
		cmp1(srst, 1'b1);
		rd_reg(ADDR_PROC_STAT, STAT_RESET_WDR);
		cmp1(fext, 1'b1);
		cyc(20);
		cmp1(srst, 1'b1);
		cyc(20);
		cmp1(srst, 1'b0);
		rd_reg(ADDR_CLK_CFG, CFG_RESET);
		wr_reg(ADDR_PROC_STAT, 8'h09);
		cyc(3);
		cmp1(ien, 1'b0);
		cmp1(een, 1'b0);
		cmp1(trun, 1'b0);
		cmp1(lven, 1'b0);
		cmp1(boren, 1'b1);
		cyc(300);
		cmp1(ien, 1'b0);
		usb <= 1'b0;
		cyc(5);
		cmp1(ien, 1'b1);
		cmp1(fext, 1'b0);
		cmp1(hold, 1'b1);
		cyc(100);
		cmp1(hold, 1'b1);
		usb <= 1'b1;
		cyc(80);
		cmp1(hold, 1'b0);
		cmp1(lven, 1'b1);
		wr_reg(ADDR_WDOG_RESTART, 8'h00);
		wr_reg(ADDR_CLK_CFG, 8'h08);
		cyc(2);
		cmp1(lven, 1'b0);
		cmp1(boren, 1'b1);
		bor <= 1'b1;
		cyc(5);
		cmp1(srst, 1'b1);
		cmp1(lven, 1'b1);
		bor <= 1'b0;
		cyc(10);
		cmp1(srst, 1'b1);
		cyc(SET);
		cmp1(srst, 1'b0);
		cmp1(ien, 1'b1);
		rd_reg(ADDR_PROC_STAT, STAT_RESET_LVR);
		rd_reg(ADDR_CLK_CFG, CFG_RESET);
		wr_reg(ADDR_PROC_STAT, 8'h09);
		cyc(3);
		cmp1(trun, 1'b0);
		irq <= 1'b1;
		cyc(5);
		cmp1(ien, 1'b1);
		cmp1(hold, 1'b1);
		irq <= 1'b0;
		cyc(170);
		cmp1(hold, 1'b0);
		wr_reg(ADDR_CLK_CFG, 8'h81);
		cyc(100);
		cmp1(hold, 1'b1);
		cyc(20);
		cmp1(hold, 1'b0);
		cmp1(fext, 1'b1);
		close_out;
	end
endmodule : clock_reset_suspend_control_tb_top
